//--- rtl/apms_consts.svh
// Constants of the converter power-mode sequencer: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the top module.
`ifndef APMS_CONSTS_SVH
`define APMS_CONSTS_SVH

// Byte addresses of the register words
`define APMS_ADDR_SHARED0   32'h0000_0000
`define APMS_ADDR_SHARED1   32'h0000_0004
`define APMS_ADDR_RES_HIGH  32'h0000_0008
`define APMS_ADDR_RES_LOW   32'h0000_000c
`define APMS_ADDR_WDT_CTRL  32'h0000_0010
`define APMS_ADDR_IRQ_STAT  32'h0000_0014
`define APMS_ADDR_IRQ_MASK  32'h0000_0018

// Main control field positions
`define APMS_CM_ON          0
`define APMS_CM_GO          1
`define APMS_CM_CHAN_LSB    2
`define APMS_CM_VREF_LSB    6
// Timing field positions
`define APMS_TC_CLK_LSB     0
`define APMS_TC_ACQ_LSB     3
`define APMS_TC_CAL         6
`define APMS_TC_JUST        7
// Shared select position in the watchdog control word
`define APMS_WDT_SHR        4
// Status and mask bits
`define APMS_IRQ_DONE       0
`define APMS_IRQ_CAL        1

// Reset values
`define APMS_RST_BYTE       8'h00
`define APMS_RST_OFFSET     10'h000
// Implemented bits of the pin configuration words
`define APMS_PIN_LOW_MASK   8'h9f
`define APMS_PIN_HIGH_MASK  8'hfc

// Timing counts
`define APMS_CONV_TADS      5'd11
`define APMS_HOLD_TADS      5'd2
`define APMS_INSTR_CYCLES   3'd4
// AXI responses
`define APMS_RESP_OKAY      2'b00
`define APMS_RESP_SLVERR    2'b10

`endif

//--- rtl/apms_pkg.sv
// Types of the converter power-mode sequencer.
// Assumes the constants header is on the include path.
`include "apms_consts.svh"

package apms_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEFER,
    ST_ACQ,
    ST_CONV,
    ST_HOLD
  } apms_state_e;

endpackage

//--- rtl/apms_top.sv
// Converter power-mode sequencer with AXI4-Lite register access.
// Assumes mclk is the sequencer's own clock, kept running in Sleep; rcTick is a
// one-cycle pulse per RC oscillator period, synchronous to mclk.
`timescale 1ns/1ps
`include "apms_consts.svh"

module apms_top
  import apms_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] awaddr,
  // AXI4-Lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [31:0] araddr,
  // AXI4-Lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Power state, clock source and trigger
  input  wire logic        cpuSleep,
  input  wire logic        rcTick,
  input  wire logic        specialTrig,
  // Analog front end
  input  wire logic [9:0]  convCode,
  output logic             sampleOn,
  output logic             dummySel,
  // Interrupt
  output logic             irq
);

  // Register state
  logic [1:0]  vrefCfg;     // Reference selection
  logic [3:0]  chanSel;     // Input channel
  logic        goBit;       // Go flag
  logic        convOn;      // Converter enable
  logic        justify;     // Result justification
  logic        calEn;       // Offset calibration enable
  logic [2:0]  acqSel;      // Acquisition time selection
  logic [2:0]  clkSel;      // Conversion clock selection
  logic [7:0]  pinLow;      // Analog pin configuration, low
  logic [7:0]  pinHigh;     // Analog pin configuration, high
  logic [7:0]  resHigh;     // Result high byte
  logic [7:0]  resLow;      // Result low byte
  logic        shrSel;      // Shared register select
  logic [1:0]  irqStat;     // Sticky events
  logic [1:0]  irqMask;     // Event mask
  logic [9:0]  offsetVal;   // Stored offset correction
  logic        calRun;      // Current conversion is a calibration
  // Sequencer state
  apms_state_e st;
  logic [4:0]  tadCnt;      // Bit periods counted in a state
  logic [2:0]  defCnt;      // Deferral cycles
  logic [5:0]  divCnt;      // Oscillator divider
  // AXI holding state
  logic        awHeld;
  logic        wHeld;
  logic [31:0] wAddr;
  logic [7:0]  wByte;
  logic        wLane0;

  // Bit period in oscillator cycles, 0 when RC is selected
  function automatic logic [6:0] tadDiv(input logic [2:0] sel);
    case (sel)
      3'b000:  tadDiv = 7'h02;
      3'b100:  tadDiv = 7'h04;
      3'b001:  tadDiv = 7'h08;
      3'b101:  tadDiv = 7'h10;
      3'b010:  tadDiv = 7'h20;
      3'b110:  tadDiv = 7'h40;
      default: tadDiv = 7'h00;
    endcase
  endfunction

  // Acquisition length in bit periods
  function automatic logic [4:0] acqTads(input logic [2:0] sel);
    case (sel)
      3'b001:  acqTads = 5'h02;
      3'b010:  acqTads = 5'h04;
      3'b011:  acqTads = 5'h06;
      3'b100:  acqTads = 5'h08;
      3'b101:  acqTads = 5'h0c;
      3'b110:  acqTads = 5'h10;
      3'b111:  acqTads = 5'h14;
      default: acqTads = 5'h00;
    endcase
  endfunction

  // True when an address reaches a legacy or a configuration word
  function automatic logic isShared(input logic [31:0] addr, input logic [31:0] base);
    isShared = (addr == base);
  endfunction

  // Mapped address check
  function automatic logic isMapped(input logic [31:0] addr);
    isMapped = (addr[31:5] == 27'h0) && (addr[1:0] == 2'b00) && (addr[4:2] != 3'd7);
  endfunction

  // Conversion clock tick
  logic       rcSel;
  logic       tadTick;
  logic [6:0] divNow;
  assign divNow = tadDiv(clkSel);
  assign rcSel  = (divNow == 7'h00);
  // RC clock keeps going in Sleep
  assign tadTick = rcSel ? rcTick : (!cpuSleep && ({1'b0, divCnt} == divNow - 7'h01));

  // Oscillator divider, halted while the oscillator sleeps
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= 6'h00;
    end else if (ce && !rcSel && !cpuSleep) begin
      divCnt <= tadTick ? 6'h00 : divCnt + 6'h01;
    end
  end

  // Write decode
  logic wrFire;
  logic wrMain;
  logic wrTiming;
  assign wrFire   = ce && awHeld && wHeld && !bvalid;
  // legacy words only when select is zero
  assign wrMain   = wrFire && wLane0 && isShared(wAddr, `APMS_ADDR_SHARED0) && !shrSel;
  assign wrTiming = wrFire && wLane0 && isShared(wAddr, `APMS_ADDR_SHARED1) && !shrSel;

  // Completion and abort
  logic convDone;
  logic abortNow;
  assign convDone = ce && (st == ST_CONV) && goBit && tadTick &&
                    (tadCnt == `APMS_CONV_TADS - 5'd1);
  assign abortNow = ce && !goBit && ((st == ST_DEFER) || (st == ST_ACQ) || (st == ST_CONV));

  // AXI write channel handshakes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `APMS_RESP_OKAY;
      wAddr   <= 32'h0;
      wByte   <= 8'h00;
      wLane0  <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awready <= 1'b0;
        wAddr   <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wready <= 1'b0;
        wByte  <= wdata[7:0];
        wLane0 <= wstrb[0];
      end
      if (wrFire) begin
        // Write performed; answer once both halves are in
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= isMapped(wAddr) ? `APMS_RESP_OKAY : `APMS_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Main control fields and go flag
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vrefCfg <= 2'b00;
      chanSel <= 4'h0;
      goBit   <= 1'b0;
      convOn  <= 1'b0;
    end else if (ce) begin
      if (wrMain) begin
        vrefCfg <= wByte[`APMS_CM_VREF_LSB +: 2];
        chanSel <= wByte[`APMS_CM_CHAN_LSB +: 4];
        convOn  <= wByte[`APMS_CM_ON];
      end
      // Go ignored if set in the write that enables the converter
      if (wrMain && !(wByte[`APMS_CM_GO] && wByte[`APMS_CM_ON])) begin
        goBit <= 1'b0;
      end else if ((wrMain && convOn) || (specialTrig && convOn)) begin
        goBit <= 1'b1;
      end else if (convDone) begin
        goBit <= 1'b0;
      end
    end
  end

  // Timing fields and shared words
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      justify <= 1'b0;
      calEn   <= 1'b0;
      acqSel  <= 3'b000;
      clkSel  <= 3'b000;
      pinLow  <= `APMS_RST_BYTE;
      pinHigh <= `APMS_RST_BYTE;
      shrSel  <= 1'b0;
      irqMask <= 2'b00;
    end else if (ce && wrFire && wLane0) begin
      if (wrTiming) begin
        justify <= wByte[`APMS_TC_JUST];
        calEn   <= wByte[`APMS_TC_CAL];
        acqSel  <= wByte[`APMS_TC_ACQ_LSB +: 3];
        clkSel  <= wByte[`APMS_TC_CLK_LSB +: 3];
      end
      // configuration words only when select is one
      if (shrSel && isShared(wAddr, `APMS_ADDR_SHARED0)) begin
        pinLow <= wByte & `APMS_PIN_LOW_MASK;
      end
      if (shrSel && isShared(wAddr, `APMS_ADDR_SHARED1)) begin
        pinHigh <= wByte & `APMS_PIN_HIGH_MASK;
      end
      if (wAddr == `APMS_ADDR_WDT_CTRL) begin
        shrSel <= wByte[`APMS_WDT_SHR];
      end
      if (wAddr == `APMS_ADDR_IRQ_MASK) begin
        irqMask <= wByte[1:0];
      end
    end
  end

  // Corrected code, floored at zero
  logic [9:0] corrCode;
  assign corrCode = (convCode >= offsetVal) ? (convCode - offsetVal) : 10'h000;

  // Result words and offset store
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resHigh   <= `APMS_RST_BYTE;
      resLow    <= `APMS_RST_BYTE;
      offsetVal <= `APMS_RST_OFFSET;
    end else if (ce) begin
      if (convDone && calRun) begin
        offsetVal <= convCode;
      end else if (convDone) begin
        resHigh <= justify ? {6'h00, corrCode[9:8]} : corrCode[9:2];
        resLow  <= justify ? corrCode[7:0] : {corrCode[1:0], 6'h00};
      end else if (wrFire && wLane0) begin
        if (wAddr == `APMS_ADDR_RES_HIGH) begin
          resHigh <= wByte;
        end
        if (wAddr == `APMS_ADDR_RES_LOW) begin
          resLow <= wByte;
        end
      end
    end
  end

  // Sticky events, set beats write-one-to-clear
  logic [1:0] evSet;
  logic [1:0] evClr;
  assign evSet = {convDone && calRun, convDone};
  assign evClr = (wrFire && wLane0 && wAddr == `APMS_ADDR_IRQ_STAT) ? wByte[1:0] : 2'b00;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat <= 2'b00;
      irq     <= 1'b0;
    end else if (ce) begin
      irqStat <= (irqStat & ~evClr) | evSet;
      irq     <= |(irqStat & irqMask);
    end
  end

  // Sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st     <= ST_IDLE;
      tadCnt <= 5'h00;
      defCnt <= 3'h0;
      calRun <= 1'b0;
    end else if (ce) begin
      case (st)
        ST_IDLE: begin
          tadCnt <= 5'h00;
          defCnt <= 3'h0;
          if (goBit) begin
            calRun <= calEn;
            st <= (acqSel == 3'b000) ? ST_DEFER : ST_ACQ;
          end
        end
        ST_DEFER: begin
          if (abortNow) begin
            st <= ST_HOLD;
          end else if (defCnt == `APMS_INSTR_CYCLES - 3'd1) begin
            st <= ST_CONV;
          end else begin
            defCnt <= defCnt + 3'h1;
          end
        end
        ST_ACQ: begin
          if (abortNow) begin
            st     <= ST_HOLD;
            tadCnt <= 5'h00;
          end else if (tadTick && tadCnt == acqTads(acqSel) - 5'd1) begin
            st     <= ST_CONV;
            tadCnt <= 5'h00;
          end else if (tadTick) begin
            tadCnt <= tadCnt + 5'h01;
          end
        end
        ST_CONV: begin
          // Idle mode has no effect here
          if (abortNow || convDone) begin
            st     <= ST_HOLD;
            tadCnt <= 5'h00;
          end else if (tadTick) begin
            tadCnt <= tadCnt + 5'h01;
          end
        end
        ST_HOLD: begin
          if (tadTick && tadCnt == `APMS_HOLD_TADS - 5'd1) begin
            st     <= ST_IDLE;
            tadCnt <= 5'h00;
            calRun <= 1'b0;
          end else if (tadTick) begin
            tadCnt <= tadCnt + 5'h01;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // Front-end controls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sampleOn <= 1'b0;
      dummySel <= 1'b0;
    end else if (ce) begin
      sampleOn <= convOn && ((st == ST_IDLE) || (st == ST_ACQ) || (st == ST_DEFER));
      dummySel <= calRun && (st != ST_IDLE);
    end
  end

  // Read data with shared-address selection
  logic [7:0] mainRd;
  logic [7:0] timingRd;
  logic [7:0] rdByte;
  assign mainRd   = {vrefCfg, chanSel, goBit, convOn};
  assign timingRd = {justify, calEn, acqSel, clkSel};
  always_comb begin
    rdByte = 8'h00;
    case (araddr)
      `APMS_ADDR_SHARED0:  rdByte = shrSel ? pinLow : mainRd;
      `APMS_ADDR_SHARED1:  rdByte = shrSel ? pinHigh : timingRd;
      `APMS_ADDR_RES_HIGH: rdByte = resHigh;
      `APMS_ADDR_RES_LOW:  rdByte = resLow;
      `APMS_ADDR_WDT_CTRL: rdByte = {3'b000, shrSel, 4'h0};
      `APMS_ADDR_IRQ_STAT: rdByte = {6'h00, irqStat};
      `APMS_ADDR_IRQ_MASK: rdByte = {6'h00, irqMask};
      default:             rdByte = 8'h00;
    endcase
  end

  // AXI read channel
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `APMS_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h0, rdByte};
        rresp   <= isMapped(araddr) ? `APMS_RESP_OKAY : `APMS_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Checks
  a_done_sets_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    convDone && !(wrMain && wByte[`APMS_CM_GO]) |=> irqStat[0] && !goBit && st == ST_HOLD)
    else $error("completion did not set flag and clear go");
  a_zero_acq_defers: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
    st == ST_IDLE && goBit && acqSel == 3'b000 |=> st == ST_DEFER [*4] ##1 st != ST_DEFER)
    else $error("deferral not one instruction long");
  a_conv_eleven_tads: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && st == ST_CONV && goBit && tadTick |=>
    st == (($past(tadCnt) == 5'd10) ? ST_HOLD : ST_CONV))
    else $error("conversion length wrong");
  a_legacy_read_map: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && arvalid && arready && araddr == `APMS_ADDR_SHARED0 && !shrSel
    |=> rdata[7:0] == $past(mainRd))
    else $error("legacy word not visible");
  a_config_read_map: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && arvalid && arready && araddr == `APMS_ADDR_SHARED1 && shrSel
    |=> rdata[7:0] == $past(pinHigh))
    else $error("configuration word not visible");
  a_cal_keeps_result: assert property (@(posedge mclk) disable iff (!rst_b)
    convDone && calRun |=> $stable(resHigh) && $stable(resLow) && offsetVal == $past(convCode))
    else $error("calibration touched result");
  a_cal_no_channel: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && st == ST_CONV && calRun |=> dummySel)
    else $error("channel sampled in calibration");
  a_sleep_rc_advance: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cpuSleep && rcSel && rcTick && st == ST_CONV && goBit |=> tadCnt != $past(tadCnt))
    else $error("sequencer stalled in sleep");
  a_cal_go_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    convDone && calRun && !wrMain && !specialTrig |=> !goBit ##1 irqStat[1])
    else $error("calibration poll never ends");
  a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
    ce |=> irq == |($past(irqStat) & $past(irqMask)))
    else $error("interrupt level wrong");
  a_wr_resp_once: assert property (@(posedge mclk) disable iff (!rst_b)
    wrFire |=> bvalid && !awready && !wready)
    else $error("write answer missing");

endmodule

//--- testbench/apms_top_tb_top.sv
// Self-checking bench of the converter sequencer: AXI4-Lite register traffic,
// RC-timed conversions, calibration, abort, trigger and interrupt handling.
// Assumes the design is driven only through its ports; rcTick is made here.
`timescale 1ns/1ps
`include "apms_consts.svh"

module apms_top_tb_top;
  import apms_pkg::*;

  // Clock, reset and design ports
  logic        mclk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cpuSleep, rcTick, specialTrig;
  logic        sampleOn, dummySel, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [9:0]  convCode, offs;
  logic [15:0] lastRes;
  logic [31:0] rd, seed;
  int          n_fail, total_checks, cyc, nCyc;

  apms_top i_apms_top (.mclk(mclk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .cpuSleep(cpuSleep), .rcTick(rcTick), .specialTrig(specialTrig),
    .convCode(convCode), .sampleOn(sampleOn), .dummySel(dummySel), .irq(irq));

  // Free-running 125 MHz clock
  always #4 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction

  // Offset-corrected, justified result
  function automatic logic [15:0] res(input logic [9:0] c, input logic j);
    logic [9:0] v;
    v = (c > offs) ? c - offs : 10'h000;
    res = j ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic fail(input string m);
    n_fail = n_fail + 1;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  // Compare a word
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks = total_checks + 1;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask

  // Compare a single output bit
  task automatic chk_bit(input logic g, input logic e, input string m);
    total_checks = total_checks + 1;
    if (g !== e) fail($sformatf("%s got %b exp %b", m, g, e));
  endtask

  // Write with both channels offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    forever begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (n > 1000) begin
        fail("write hang");
        break;
      end
    end
  endtask

  // Read one word
  task automatic rdw(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    forever begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (n > 1000) begin
        fail("read hang");
        break;
      end
    end
  endtask

  // Read and compare value and response
  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    rdw(a, rd, rs);
    chk_word(rd, e, "read data");
    chk_word({30'h0, rs}, {30'h0, er}, "read resp");
  endtask

  // One RC oscillator period
  task automatic tick;
    @(posedge mclk) rcTick <= 1'b1;
    @(posedge mclk) rcTick <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  // Full conversion on the RC clock; counts ticks until the interrupt
  task automatic conv(input logic [2:0] acq, input logic j, input logic cal,
                      input logic trig, input int expT);
    int    n;
    logic [9:0]  c;
    logic [15:0] e;
    seed = lfsr(seed);
    c = seed[9:0];
    convCode <= c;
    wr(`APMS_ADDR_SHARED1, {24'h0, j, cal, acq, 3'b011}, rs);
    if (trig) begin
      @(posedge mclk) specialTrig <= 1'b1;
      @(posedge mclk) specialTrig <= 1'b0;
    end else wr(`APMS_ADDR_SHARED0, 32'h03, rs);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      tick;
      n++;
      if (n == 1) chk_bit(dummySel, cal, "dummy select");
    end
    chk_word(n, expT, "ticks to done");
    e = cal ? lastRes : res(c, j);
    if (cal) offs = c;
    lastRes = e;
    rchk(`APMS_ADDR_RES_HIGH, {24'h0, e[15:8]}, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_RES_LOW, {24'h0, e[7:0]}, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_SHARED0, 32'h01, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_IRQ_STAT, {30'h0, cal, 1'b1}, `APMS_RESP_OKAY);
    // Mask off, back on, then clear by writing ones
    wr(`APMS_ADDR_IRQ_MASK, 32'h0, rs);
    repeat (2) @(posedge mclk);
    chk_bit(irq, 1'b0, "masked irq");
    wr(`APMS_ADDR_IRQ_MASK, 32'h3, rs);
    repeat (2) @(posedge mclk);
    chk_bit(irq, 1'b1, "unmasked irq");
    wr(`APMS_ADDR_IRQ_STAT, 32'h3, rs);
    repeat (2) @(posedge mclk);
    chk_bit(irq, 1'b0, "cleared irq");
    // Hold period, then sampling resumes
    tick;
    tick;
    chk_bit(sampleOn, 1'b1, "sampling resumed");
    $display("conversion test done acq=%b cal=%b", acq, cal);
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Expected ticks per acquisition code: acquisition TADs plus eleven; with no
  // acquisition the first RC tick lands inside the deferral and is not counted
  int acqT [8] = '{12, 13, 15, 17, 19, 23, 27, 31};

  initial begin
    mclk = 0; rst_b = 0; ce = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 0; wdata = 0; wstrb = 4'hf; araddr = 0; cpuSleep = 0;
    rcTick = 0; specialTrig = 0; convCode = 0; offs = 0; seed = 32'h6613;
    n_fail = 0; total_checks = 0; cyc = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values and unmapped addresses
    for (int a = 0; a < 7; a++) rchk(a * 4, 32'h0, `APMS_RESP_OKAY);
    rchk(32'h20, 32'h0, `APMS_RESP_SLVERR);
    wr(32'h1c, 32'hff, rs);
    chk_word({30'h0, rs}, {30'h0, `APMS_RESP_SLVERR}, "unmapped write");
    // Shared bank: pin configuration visible only with select set
    wr(`APMS_ADDR_WDT_CTRL, 32'h10, rs);
    wr(`APMS_ADDR_SHARED0, 32'hff, rs);
    wr(`APMS_ADDR_SHARED1, 32'hff, rs);
    rchk(`APMS_ADDR_SHARED0, {24'h0, `APMS_PIN_LOW_MASK}, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_SHARED1, {24'h0, `APMS_PIN_HIGH_MASK}, `APMS_RESP_OKAY);
    wr(`APMS_ADDR_WDT_CTRL, 32'h0, rs);
    rchk(`APMS_ADDR_SHARED0, 32'h0, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_SHARED1, 32'h0, `APMS_RESP_OKAY);
    $display("register test done");
    // Result registers writable
    wr(`APMS_ADDR_RES_HIGH, 32'ha5, rs);
    wr(`APMS_ADDR_RES_LOW, 32'h5a, rs);
    lastRes = 16'ha55a;
    wr(`APMS_ADDR_IRQ_MASK, 32'h3, rs);
    wr(`APMS_ADDR_SHARED0, 32'h01, rs);
    cpuSleep <= 1'b1;
    conv(3'b010, 1'b1, 1'b1, 1'b0, 15);
    for (int k = 0; k < 8; k++) conv(k[2:0], k[0], 1'b0, 1'b0, acqT[k]);
    conv(3'b001, 1'b1, 1'b0, 1'b1, 13);
    // Abort in mid-conversion keeps the result
    wr(`APMS_ADDR_SHARED0, 32'h03, rs);
    repeat (5) tick;
    // Clock enable low freezes the conversion in mid-flight
    ce <= 1'b0;
    repeat (20) tick;
    ce <= 1'b1;
    rchk(`APMS_ADDR_IRQ_STAT, 32'h0, `APMS_RESP_OKAY);
    wr(`APMS_ADDR_SHARED0, 32'h01, rs);
    repeat (20) tick;
    rchk(`APMS_ADDR_IRQ_STAT, 32'h0, `APMS_RESP_OKAY);
    rchk(`APMS_ADDR_RES_LOW, {24'h0, lastRes[7:0]}, `APMS_RESP_OKAY);
    // Trigger ignored while converter off
    wr(`APMS_ADDR_SHARED0, 32'h00, rs);
    @(posedge mclk) specialTrig <= 1'b1;
    @(posedge mclk) specialTrig <= 1'b0;
    rchk(`APMS_ADDR_SHARED0, 32'h0, `APMS_RESP_OKAY);
    $display("abort and trigger test done");
    // Divided clock, awake: 4 mclk deferral, 11 periods of 2 mclk, flag and
    // interrupt lag; the free-running divider phase adds zero or one cycle
    cpuSleep <= 1'b0;
    wr(`APMS_ADDR_SHARED1, 32'h00, rs);
    wr(`APMS_ADDR_SHARED0, 32'h01, rs);
    wr(`APMS_ADDR_SHARED0, 32'h03, rs);
    nCyc = 0;
    while (irq !== 1'b1 && nCyc < 100) begin
      @(posedge mclk);
      nCyc++;
    end
    chk_bit(nCyc == 27 || nCyc == 28, 1'b1, "divided clock length");
    $display("divided clock test done");
    final_report;
  end
endmodule
